//--- rtl/dvic_sources.sv
// maps peripheral and wake-up requests onto the 32 channels
`include "dvic_params.svh"
module dvic_sources (
  input  wire logic        wdt_req,
  input  wire logic        fw_req,
  input  wire logic        dbg_rx,
  input  wire logic        dbg_tx,
  input  wire logic [7:0]  timer_input_capture_flag,
  input  wire logic [7:0]  timer_output_compare_flag,
  input  wire logic [3:0]  timer_overflow,
  input  wire logic        usb_hp,
  input  wire logic        usb_lp,
  input  wire logic        clock_control_unit_irq,
  input  wire logic        mac_irq,
  input  wire logic [7:0]  dma_ch_irq,
  input  wire logic        can_irq,
  input  wire logic [7:0]  motor_control_unit_irq,
  input  wire logic        adc_eoc,
  input  wire logic [14:0] uart_irq,
  input  wire logic [5:0]  twi_irq,
  input  wire logic        sync_serial_port_zero_irq,
  input  wire logic        sync_serial_port_one_irq,
  input  wire logic        low_voltage_detector_warn,
  input  wire logic        rtc_alarm,
  input  wire logic        rtc_tamper,
  input  wire logic        rtc_periodic,
  input  wire logic        usb_resume,
  input  wire logic [29:0] wake_pin,
  input  wire logic [29:0] wake_en,
  input  wire logic [1:0]  spare_irq,
  output logic      [31:0] chan
);
  // pins: [5:0] port3 2-7, [13:6] port5, [21:14] port6, [29:22] port7
  logic [29:0] wake_live;
  logic        rtc_any;
  logic [7:0]  grp0;
  assign wake_live = wake_pin & wake_en;
  assign rtc_any   = rtc_alarm | rtc_tamper | rtc_periodic;
  assign grp0      = {usb_resume, rtc_any, wake_live[5:0]};

  assign chan[`DVIC_CH_WATCHDOG] = wdt_req;
  assign chan[`DVIC_CH_FIRMWARE] = fw_req;
  assign chan[2] = dbg_rx;
  assign chan[3] = dbg_tx;
  genvar t;
  generate
    for (t = 0; t < 4; t++) begin : g_tim
      assign chan[`DVIC_CH_TIMER0 + t] =
        |timer_input_capture_flag[2*t +: 2] |
        |timer_output_compare_flag[2*t +: 2] | timer_overflow[t];
    end
    for (t = 0; t < 3; t++) begin : g_uart
      assign chan[`DVIC_CH_UART0 + t] = |uart_irq[5*t +: 5];
    end
    for (t = 0; t < 2; t++) begin : g_twi
      assign chan[`DVIC_CH_TWI0 + t] = |twi_irq[3*t +: 3];
    end
  endgenerate
  assign chan[`DVIC_CH_USB_HP]     = usb_hp;
  assign chan[`DVIC_CH_USB_HP + 1] = usb_lp;
  assign chan[10] = clock_control_unit_irq;
  assign chan[11] = mac_irq;
  assign chan[`DVIC_CH_DMA] = |dma_ch_irq;
  assign chan[13] = can_irq;
  assign chan[14] = |motor_control_unit_irq;
  assign chan[`DVIC_CH_ADC] = adc_eoc;
  assign chan[21] = sync_serial_port_zero_irq;
  assign chan[22] = sync_serial_port_one_irq;
  assign chan[`DVIC_CH_LVD] = low_voltage_detector_warn;
  assign chan[`DVIC_CH_RTC] = rtc_any;
  assign chan[`DVIC_CH_WAKE_ANY] = |wake_live | rtc_any | usb_resume;
  assign chan[`DVIC_CH_WAKE_GRP]     = |grp0;
  assign chan[`DVIC_CH_WAKE_GRP + 1] = |wake_live[13:6];
  assign chan[`DVIC_CH_WAKE_GRP + 2] = |wake_live[21:14];
  assign chan[`DVIC_CH_WAKE_GRP + 3] = |wake_live[29:22];
  assign chan[31:30] = spare_irq;
endmodule // dvic_sources

//--- rtl/dvic_top.sv
// dual chained vectored interrupt controller, top level
`include "dvic_params.svh"
module dvic_top (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        wdt_req,
  input  wire logic        fw_req,
  input  wire logic        dbg_rx,
  input  wire logic        dbg_tx,
  input  wire logic [7:0]  timer_input_capture_flag,
  input  wire logic [7:0]  timer_output_compare_flag,
  input  wire logic [3:0]  timer_overflow,
  input  wire logic        usb_hp,
  input  wire logic        usb_lp,
  input  wire logic        clock_control_unit_irq,
  input  wire logic        mac_irq,
  input  wire logic [7:0]  dma_ch_irq,
  input  wire logic        can_irq,
  input  wire logic [7:0]  motor_control_unit_irq,
  input  wire logic        adc_eoc,
  input  wire logic [14:0] uart_irq,
  input  wire logic [5:0]  twi_irq,
  input  wire logic        sync_serial_port_zero_irq,
  input  wire logic        sync_serial_port_one_irq,
  input  wire logic        low_voltage_detector_warn,
  input  wire logic        rtc_alarm,
  input  wire logic        rtc_tamper,
  input  wire logic        rtc_periodic,
  input  wire logic        usb_resume,
  input  wire logic [29:0] wake_pin,
  input  wire logic [29:0] wake_en,
  input  wire logic [1:0]  spare_irq,
  input  wire logic [31:0] chan_enable,
  input  wire logic [31:0] chan_force,
  input  wire logic        fiq_enable,
  input  wire logic [4:0]  fiq_channel,
  input  wire logic [63:0] primary_map,
  input  wire logic [63:0] secondary_map,
  input  wire logic        vect_wr,
  input  wire logic [4:0]  vect_wr_idx,
  input  wire logic [31:0] vect_wr_data,
  input  wire logic        vec_rd,
  input  wire logic        bc_load,
  input  wire logic [31:0] bc_tag_in,
  input  wire logic [31:0] bc_instr_in,
  input  wire logic        bc_fetch,
  input  wire logic [31:0] bc_fetch_addr,
  output logic             fast_interrupt_request,
  output logic             irq_out,
  output logic             vec_valid,
  output logic      [31:0] vec_addr,
  output logic      [4:0]  vec_src,
  output logic             vec_none,
  output logic             bc_hit,
  output logic             bc_miss,
  output logic      [31:0] bc_data
);
  // wake pins come from outside the clock domain
  logic [29:0] wake_s1;
  logic [29:0] wake_s2;
  logic [31:0] chan;
  logic [31:0] fiq_mask;
  logic        fiq_raw;
  logic        sec_any;
  logic        sec_valid;
  logic [4:0]  sec_idx;
  logic        pri_any;
  logic        win_valid;
  logic [4:0]  win_idx;
  logic        irq_raw;
  logic        win_valid_q;
  logic [4:0]  win_idx_q;
  logic        bc_valid;
  logic [31:0] bc_tag;
  logic [31:0] bc_instr;
  logic        bc_match;
  logic [31:0] next_vec_addr;
  dvic_pkg::dvic_word_t  vect_table [`DVIC_NUM_CH];
  dvic_pkg::dvic_rd_state_t rd_state;
  dvic_pkg::dvic_rd_state_t next_rd_state;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wake_s1 <= 30'h0;
      wake_s2 <= 30'h0;
    end else if (ce) begin
      wake_s1 <= wake_pin;
      wake_s2 <= wake_s1;
    end
  end

  dvic_sources u_sources (
    .wdt_req                   (wdt_req),
    .fw_req                    (fw_req),
    .dbg_rx                    (dbg_rx),
    .dbg_tx                    (dbg_tx),
    .timer_input_capture_flag  (timer_input_capture_flag),
    .timer_output_compare_flag (timer_output_compare_flag),
    .timer_overflow            (timer_overflow),
    .usb_hp                    (usb_hp),
    .usb_lp                    (usb_lp),
    .clock_control_unit_irq    (clock_control_unit_irq),
    .mac_irq                   (mac_irq),
    .dma_ch_irq                (dma_ch_irq),
    .can_irq                   (can_irq),
    .motor_control_unit_irq    (motor_control_unit_irq),
    .adc_eoc                   (adc_eoc),
    .uart_irq                  (uart_irq),
    .twi_irq                   (twi_irq),
    .sync_serial_port_zero_irq (sync_serial_port_zero_irq),
    .sync_serial_port_one_irq  (sync_serial_port_one_irq),
    .low_voltage_detector_warn (low_voltage_detector_warn),
    .rtc_alarm                 (rtc_alarm),
    .rtc_tamper                (rtc_tamper),
    .rtc_periodic              (rtc_periodic),
    .usb_resume                (usb_resume),
    .wake_pin                  (wake_s2),
    .wake_en                   (wake_en),
    .spare_irq                 (spare_irq),
    .chan                      (chan)
  );

  // selected channel leaves the vectored path for the fast one
  assign fiq_mask = fiq_enable ? (32'h1 << fiq_channel) : 32'h0;
  assign fiq_raw  = |((chan | chan_force) & chan_enable & fiq_mask);

  dvic_unit #(.BASE(`DVIC_SECOND_BASE)) u_secondary_interrupt_unit (
    .src         (chan[31:16]),
    .force_req   (chan_force[31:16]),
    .enable      (chan_enable[31:16]),
    .fiq_mask    (fiq_mask[31:16]),
    .slot_map    (secondary_map),
    .chain_valid (1'b0),
    .chain_idx   (5'h0),
    .own_any     (sec_any),
    .valid       (sec_valid),
    .idx         (sec_idx)
  );

  dvic_unit #(.BASE(`DVIC_PRIMARY_BASE)) u_primary_interrupt_unit (
    .src         (chan[15:0]),
    .force_req   (chan_force[15:0]),
    .enable      (chan_enable[15:0]),
    .fiq_mask    (fiq_mask[15:0]),
    .slot_map    (primary_map),
    .chain_valid (sec_valid),
    .chain_idx   (sec_idx),
    .own_any     (pri_any),
    .valid       (win_valid),
    .idx         (win_idx)
  );

  assign irq_raw = pri_any | sec_any;
  assign bc_match = bc_valid && (bc_fetch_addr == bc_tag);
  assign next_vec_addr = win_valid_q ? vect_table[win_idx_q]
                                     : `DVIC_DEF_VECT;
  assign next_rd_state = (ce && vec_rd) ? dvic_pkg::DVIC_RD_ANSWER
                                        : dvic_pkg::DVIC_RD_IDLE;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fast_interrupt_request <= 1'b0;
      irq_out                <= 1'b0;
      win_valid_q            <= 1'b0;
      win_idx_q              <= 5'h0;
    end else if (ce) begin
      fast_interrupt_request <= fiq_raw;
      irq_out                <= irq_raw & ~fiq_raw;
      win_valid_q            <= win_valid;
      win_idx_q              <= win_idx;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `DVIC_NUM_CH; i++) begin
        vect_table[i] <= `DVIC_DEF_VECT;
      end
    end else if (ce && vect_wr) begin
      vect_table[vect_wr_idx] <= vect_wr_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_state  <= dvic_pkg::DVIC_RD_IDLE;
      vec_valid <= 1'b0;
      vec_addr  <= `DVIC_DEF_VECT;
      vec_src   <= 5'h0;
      vec_none  <= 1'b0;
    end else if (ce) begin
      rd_state  <= next_rd_state;
      vec_valid <= vec_rd;
      if (vec_rd) begin
        vec_addr <= next_vec_addr;
        vec_src  <= win_idx_q;
        vec_none <= ~win_valid_q;
      end
    end
  end

  // extra cache entry: vector-read instruction served in one access
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bc_valid <= 1'b0;
      bc_tag   <= `DVIC_DEF_BC_TAG;
      bc_instr <= `DVIC_DEF_BC_INSTR;
    end else if (ce && bc_load) begin
      bc_valid <= 1'b1;
      bc_tag   <= bc_tag_in;
      bc_instr <= bc_instr_in;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bc_hit  <= 1'b0;
      bc_miss <= 1'b0;
      bc_data <= 32'h0;
    end else if (ce) begin
      bc_hit  <= bc_fetch & bc_match;
      bc_miss <= bc_fetch & ~bc_match;
      if (bc_fetch && bc_match) begin
        bc_data <= bc_instr;
      end
    end
  end

  property p_fast_masks_vec;
    @(posedge mclk) disable iff (rst)
      fast_interrupt_request |-> !irq_out;
  endproperty
  a_fast_masks_vec: assert property (p_fast_masks_vec)
    else $error("vectored request alongside fast request");

  property p_fast_follows_sel;
    @(posedge mclk) disable iff (rst)
      (ce && fiq_enable && chan_enable[fiq_channel] &&
       chan[fiq_channel]) |=> fast_interrupt_request;
  endproperty
  a_fast_follows_sel: assert property (p_fast_follows_sel)
    else $error("selected channel did not raise fast request");

  property p_vec_or;
    @(posedge mclk) disable iff (rst)
      (ce && !fiq_enable) |=>
        irq_out == $past(|((chan | chan_force) & chan_enable));
  endproperty
  a_vec_or: assert property (p_vec_or)
    else $error("vectored request is not the OR of channels");

  property p_primary_wins;
    @(posedge mclk) disable iff (rst)
      (pri_any && sec_any) |-> win_idx < 5'h10;
  endproperty
  a_primary_wins: assert property (p_primary_wins)
    else $error("secondary unit beat primary unit");

  property p_vec_answer;
    @(posedge mclk) disable iff (rst)
      (ce && vec_rd && win_valid_q) |=>
        vec_valid && !vec_none && vec_src == $past(win_idx_q);
  endproperty
  a_vec_answer: assert property (p_vec_answer)
    else $error("vector read did not return winning source");

  property p_bc_one_access;
    @(posedge mclk) disable iff (rst)
      (ce && bc_fetch && bc_valid && bc_fetch_addr == bc_tag)
        |=> bc_hit && !bc_miss && bc_data == $past(bc_instr);
  endproperty
  a_bc_one_access: assert property (p_bc_one_access)
    else $error("cache entry missed the vector-read fetch");

  property p_force_any;
    @(posedge mclk) disable iff (rst)
      (ce && !fiq_enable && |(chan_force & chan_enable)) |=> irq_out;
  endproperty
  a_force_any: assert property (p_force_any)
    else $error("forced channel raised no vectored request");

  property p_watchdog_top;
    @(posedge mclk) disable iff (rst)
      (wdt_req && chan_enable[0] && !fiq_enable &&
       primary_map[3:0] == 4'h0) |-> win_valid && win_idx == 5'h0;
  endproperty
  a_watchdog_top: assert property (p_watchdog_top)
    else $error("watchdog request did not win slot 0");

  property p_chain_only_idle;
    @(posedge mclk) disable iff (rst)
      (!pri_any && sec_any) |-> win_idx == sec_idx && win_idx >= 5'h10;
  endproperty
  a_chain_only_idle: assert property (p_chain_only_idle)
    else $error("chained secondary winner not passed through");

  property p_bc_cold_miss;
    @(posedge mclk) disable iff (rst)
      (ce && bc_fetch && !bc_valid) |=> bc_miss && !bc_hit;
  endproperty
  a_bc_cold_miss: assert property (p_bc_cold_miss)
    else $error("empty cache entry answered a fetch");

  property p_vec_no_stray;
    @(posedge mclk) disable iff (rst)
      (ce && !vec_rd) |=>
        !vec_valid && rd_state == dvic_pkg::DVIC_RD_IDLE;
  endproperty
  a_vec_no_stray: assert property (p_vec_no_stray)
    else $error("vector answer without a read");
endmodule // dvic_top

//--- rtl/dvic_unit.sv
// one 16-slot prioritised vectored unit with chain input
`include "dvic_params.svh"
module dvic_unit #(
  parameter int BASE = 0
) (
  input  wire logic [15:0] src,
  input  wire logic [15:0] force_req,
  input  wire logic [15:0] enable,
  input  wire logic [15:0] fiq_mask,
  input  wire logic [63:0] slot_map,
  input  wire logic        chain_valid,
  input  wire logic [4:0]  chain_idx,
  output logic             own_any,
  output logic             valid,
  output logic      [4:0]  idx
);
  localparam logic [4:0] BASE5 = 5'(BASE);
  logic [15:0] live;
  logic [15:0] slot_req;
  logic [3:0]  win_slot;
  logic [3:0]  win_src;

  function automatic logic [3:0] dvic_first(input logic [15:0] v);
    logic [3:0] f;
    f = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        f = 4'(i);
      end
    end
    return f;
  endfunction

  assign live = (src | force_req) & enable & ~fiq_mask;
  genvar k;
  generate
    for (k = 0; k < 16; k++) begin : g_slot
      assign slot_req[k] = live[slot_map[4*k +: 4]];
    end
  endgenerate
  assign own_any  = |slot_req;
  assign win_slot = dvic_first(slot_req);
  assign win_src  = slot_map[4*win_slot +: 4];
  assign valid    = own_any | chain_valid;
  assign idx      = own_any ? 5'(BASE5 + {1'b0, win_src}) : chain_idx;
endmodule // dvic_unit

//--- shared/dvic_params.svh
// constants for the dual vectored interrupt controller
`ifndef DVIC_PARAMS_SVH
`define DVIC_PARAMS_SVH
`define DVIC_NUM_CH        32
`define DVIC_UNIT_CH       16
`define DVIC_MAP_W         4
`define DVIC_IDX_W         5
`define DVIC_PRIMARY_BASE  0
`define DVIC_SECOND_BASE   16
`define DVIC_CH_WATCHDOG   0
`define DVIC_CH_FIRMWARE   1
`define DVIC_CH_TIMER0     4
`define DVIC_CH_USB_HP     8
`define DVIC_CH_DMA        12
`define DVIC_CH_ADC        15
`define DVIC_CH_UART0      16
`define DVIC_CH_TWI0       19
`define DVIC_CH_LVD        23
`define DVIC_CH_RTC        24
`define DVIC_CH_WAKE_ANY   25
`define DVIC_CH_WAKE_GRP   26
`define DVIC_WAKE_PINS     30
`define DVIC_DEF_VECT      32'h0000_0000
`define DVIC_DEF_BC_TAG    32'h0000_0000
`define DVIC_DEF_BC_INSTR  32'h0000_0000
`define DVIC_VEC_LAT       1
`endif

//--- shared/dvic_pkg.sv
// types shared by the interrupt controller files
package dvic_pkg;
  typedef logic [4:0]  dvic_chan_t;
  typedef logic [31:0] dvic_word_t;
  typedef enum logic [0:0] {
    DVIC_RD_IDLE,
    DVIC_RD_ANSWER
  } dvic_rd_state_t;
endpackage

//--- tb/dual_vectored_interrupt_controller_tb_top.sv
// self-checking bench for the dual vectored interrupt controller
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end
module dual_vectored_interrupt_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] ID_MAP   = 64'hFEDC_BA98_7654_3210;
  localparam logic [63:0] REV_MAP  = 64'h0123_4567_89AB_CDEF;
  localparam logic [31:0] BC_TAG   = 32'h0000_0F00;
  localparam logic [31:0] BC_INSTR = 32'h5A5A_C3C3;
  typedef struct {int b; int c;} dvic_row_t;
  logic        mclk, rst, ce, go, blind, fiq_enable, vect_wr, bc_load;
  logic        fast_interrupt_request, irq_out, vec_valid, vec_none, bc_hit;
  logic        bc_miss, vec_rd, bc_fetch, got, got_none, got_hit;
  logic [4:0]  fiq_channel, vect_wr_idx, vec_src, got_src;
  logic [7:0]  lag;
  logic [29:0] wake_pin, wake_en;
  logic [31:0] chan_enable, chan_force, vect_wr_data, bc_tag_in, bc_instr_in;
  logic [31:0] bc_fetch_addr, vec_addr, bc_data, got_addr, got_data, bc_addr;
  logic [63:0] primary_map, secondary_map;
  logic [75:0] srcv;
  int          errors = 0;
  int          n_checks = 0;
  int          pins[8] = '{0, 5, 6, 13, 14, 21, 22, 29};
  // source bit of srcv beside the channel it must win on
  dvic_row_t rows[30] = '{
    '{0, 0}, '{1, 1}, '{2, 2}, '{3, 3},
    '{11, 7}, '{14, 5}, '{22, 6}, '{20, 4},
    '{24, 8}, '{25, 9}, '{26, 10}, '{27, 11},
    '{35, 12}, '{36, 13}, '{40, 14}, '{45, 15},
    '{50, 16}, '{55, 17}, '{60, 18}, '{63, 19}, '{64, 20},
    '{67, 21}, '{68, 22}, '{69, 23},
    '{70, 24}, '{71, 24}, '{72, 24}, '{73, 25},
    '{74, 30}, '{75, 31}};

  dvic_top i_dvic_top (
    .mclk, .rst, .ce,
    .wdt_req(srcv[0]), .fw_req(srcv[1]), .dbg_rx(srcv[2]), .dbg_tx(srcv[3]),
    .timer_input_capture_flag(srcv[11:4]),
    .timer_output_compare_flag(srcv[19:12]), .timer_overflow(srcv[23:20]),
    .usb_hp(srcv[24]), .usb_lp(srcv[25]), .clock_control_unit_irq(srcv[26]),
    .mac_irq(srcv[27]), .dma_ch_irq(srcv[35:28]), .can_irq(srcv[36]),
    .motor_control_unit_irq(srcv[44:37]), .adc_eoc(srcv[45]),
    .uart_irq(srcv[60:46]), .twi_irq(srcv[66:61]),
    .sync_serial_port_zero_irq(srcv[67]), .sync_serial_port_one_irq(srcv[68]),
    .low_voltage_detector_warn(srcv[69]), .rtc_alarm(srcv[70]),
    .rtc_tamper(srcv[71]), .rtc_periodic(srcv[72]), .usb_resume(srcv[73]),
    .spare_irq(srcv[75:74]), .wake_pin, .wake_en, .chan_enable, .chan_force,
    .fiq_enable, .fiq_channel, .primary_map, .secondary_map, .vect_wr,
    .vect_wr_idx, .vect_wr_data, .vec_rd, .bc_load, .bc_tag_in, .bc_instr_in,
    .bc_fetch, .bc_fetch_addr, .fast_interrupt_request, .irq_out, .vec_valid,
    .vec_addr, .vec_src, .vec_none, .bc_hit, .bc_miss, .bc_data);

  dvic_cpu_model i_dvic_cpu_model (
    .mclk, .rst, .go, .blind, .lag, .bc_addr, .fast_interrupt_request,
    .irq_out, .vec_valid, .vec_addr, .vec_src, .vec_none, .bc_hit, .bc_miss,
    .bc_data, .vec_rd, .bc_fetch, .bc_fetch_addr, .got, .got_src, .got_addr,
    .got_none, .got_hit, .got_data);

  always #10 mclk = ~mclk;

  function automatic logic [31:0] va(input int i);
    return 32'h0000_1000 + (32'(i) << 4);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // let the cpu model service one request; exp 32 means no winner
  task automatic irq_read(input int exp, input int l, input logic hit);
    int k;
    k = 0;
    lag = 8'(l);
    go = 1'b1;
    tick(1);
    go = 1'b0;
    while (got !== 1'b1 && k < 200) begin
      tick(1);
      k++;
    end
    if (k == 200) begin
      errors++;
      $display("CHECK FAILED t=%0t no vector read", $time);
      results();
    end
    if (exp == 32) begin
      `CHK(got_none, 1'b1, "no-winner flag")
      `CHK(got_addr, 32'h0000_0000, "no-winner address")
    end else begin
      `CHK(got_src, 5'(exp), "winning source")
      `CHK(got_addr, va(exp), "vector address")
      `CHK(got_none, 1'b0, "winner missing")
    end
    `CHK(got_hit, hit, "cache lookup")
    if (hit) `CHK(got_data, BC_INSTR, "cache instruction")
  endtask

  initial begin
    {mclk, go, blind, fiq_enable, vect_wr, bc_load, fiq_channel} = '0;
    {vect_wr_idx, lag, wake_pin, wake_en, chan_force, vect_wr_data} = '0;
    {srcv, bc_addr, bc_tag_in, bc_instr_in} = '0;
    rst = 1'b1;
    ce = 1'b1;
    chan_enable = '1;
    primary_map = ID_MAP;
    secondary_map = ID_MAP;
    tick(15);
    `CHK(irq_out, 1'b0, "irq in reset")
    `CHK(fast_interrupt_request, 1'b0, "fast in reset")
    `CHK(vec_addr, 32'h0000_0000, "vector in reset")
    tick(1);
    rst = 1'b0;
    tick(1);
    done("reset");
    for (int i = 0; i < 32; i++) begin
      vect_wr = 1'b1;
      vect_wr_idx = 5'(i);
      vect_wr_data = va(i);
      tick(1);
    end
    vect_wr = 1'b0;
    chan_force = 32'h0000_0001;
    irq_read(0, 0, 1'b0);
    bc_load = 1'b1;
    bc_tag_in = BC_TAG;
    bc_instr_in = BC_INSTR;
    tick(1);
    bc_load = 1'b0;
    bc_addr = BC_TAG;
    chan_force = '0;
    tick(3);
    foreach (rows[r]) begin
      srcv[rows[r].b] = 1'b1;
      irq_read(rows[r].c, 0, 1'b1);
      srcv = '0;
      tick(3);
      `CHK(irq_out, 1'b0, "irq stuck")
    end
    done("sources");
    for (int i = 0; i < 32; i++) begin
      chan_force = 32'h0000_0001 << i;
      irq_read(i, i % 4 * 7, 1'b1);
    end
    done("force");
    chan_force = '1;
    irq_read(0, 0, 1'b1);
    chan_force = 32'hC000_0000;
    irq_read(30, 0, 1'b1);
    chan_force = 32'h0001_8000;
    irq_read(15, 2, 1'b1);
    primary_map = REV_MAP;
    chan_force = 32'h0000_8001;
    irq_read(15, 0, 1'b1);
    chan_force = 32'h0001_0001;
    irq_read(0, 0, 1'b1);
    secondary_map = REV_MAP;
    chan_force = 32'h8001_0000;
    irq_read(31, 0, 1'b1);
    primary_map = ID_MAP;
    secondary_map = ID_MAP;
    chan_force = 32'h0000_0020;
    chan_enable = 32'hFFFF_FFDF;
    tick(3);
    `CHK(irq_out, 1'b0, "disabled channel raised irq")
    chan_enable = '1;
    done("priority");
    fiq_enable = 1'b1;
    fiq_channel = 5'h03;
    chan_force = 32'h0000_0028;
    tick(3);
    `CHK(fast_interrupt_request, 1'b1, "fast not raised")
    `CHK(irq_out, 1'b0, "irq beside fast")
    chan_force = 32'h0000_0008;
    tick(3);
    `CHK(irq_out, 1'b0, "fast channel in vectored path")
    chan_force = 32'h0000_0020;
    irq_read(5, 0, 1'b1);
    `CHK(fast_interrupt_request, 1'b0, "fast stuck")
    fiq_channel = 5'h1F;
    chan_force = 32'h8000_0000;
    tick(3);
    `CHK(fast_interrupt_request, 1'b1, "fast on last channel")
    fiq_enable = 1'b0;
    chan_force = '0;
    done("fast");
    chan_enable = 32'h0200_0000;
    wake_en = '1;
    wake_pin = 30'h0002_0000;
    irq_read(25, 0, 1'b1);
    wake_pin = '0;
    srcv[73] = 1'b1;
    irq_read(25, 0, 1'b1);
    srcv = '0;
    wake_en = 30'h3FFD_FFFF;
    wake_pin = 30'h0002_0000;
    tick(6);
    `CHK(irq_out, 1'b0, "disabled pin raised irq")
    wake_en = '1;
    wake_pin = '0;
    chan_enable = 32'h3C00_0000;
    foreach (pins[p]) begin
      tick(4);
      wake_pin = 30'h0000_0001 << pins[p];
      irq_read(26 + (pins[p] + 2) / 8, 0, 1'b1);
      wake_pin = '0;
    end
    srcv[71] = 1'b1;
    irq_read(26, 0, 1'b1);
    srcv = '0;
    done("wake");
    chan_enable = '1;
    tick(4);
    blind = 1'b1;
    irq_read(32, 0, 1'b1);
    blind = 1'b0;
    bc_addr = ~BC_TAG;
    chan_force = 32'h0000_0002;
    irq_read(1, 4, 1'b0);
    done("vector");
    chan_force = '0;
    tick(3);
    ce = 1'b0;
    chan_force = 32'h0000_0004;
    tick(3);
    `CHK(irq_out, 1'b0, "irq moved while frozen")
    ce = 1'b1;
    tick(2);
    `CHK(irq_out, 1'b1, "irq after enable")
    rst = 1'b1;
    tick(2);
    `CHK(irq_out, 1'b0, "irq through reset")
    `CHK(vec_addr, 32'h0000_0000, "vector through reset")
    rst = 1'b0;
    chan_force = '0;
    bc_addr = BC_TAG;
    tick(1);
    blind = 1'b1;
    irq_read(32, 0, 1'b0);
    blind = 1'b0;
    done("mid reset");
    results();
  end
endmodule // dual_vectored_interrupt_controller_tb_top

//--- tb/dvic_cpu_model.sv
// cpu-side model that services vectored requests from the controller
module dvic_cpu_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        blind,
  input  wire logic [7:0]  lag,
  input  wire logic [31:0] bc_addr,
  input  wire logic        fast_interrupt_request,
  input  wire logic        irq_out,
  input  wire logic        vec_valid,
  input  wire logic [31:0] vec_addr,
  input  wire logic [4:0]  vec_src,
  input  wire logic        vec_none,
  input  wire logic        bc_hit,
  input  wire logic        bc_miss,
  input  wire logic [31:0] bc_data,
  output logic             vec_rd,
  output logic             bc_fetch,
  output logic      [31:0] bc_fetch_addr,
  output logic             got,
  output logic      [4:0]  got_src,
  output logic      [31:0] got_addr,
  output logic             got_none,
  output logic             got_hit,
  output logic      [31:0] got_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] st;
  logic [7:0] cnt;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {st, cnt, vec_rd, bc_fetch, bc_fetch_addr, got} <= '0;
      {got_src, got_addr, got_none, got_hit, got_data} <= '0;
    end else begin
      vec_rd        <= 1'b0;
      bc_fetch      <= 1'b0;
      got           <= 1'b0;
      // idle address wanders so a stale value never looks valid
      bc_fetch_addr <= ~bc_fetch_addr;
      case (st)
        3'h0: if (go) st <= 3'h1;
        // vectored request is taken only while no fast request is raised, or at once when blind
        3'h1: if ((irq_out && !fast_interrupt_request) || blind) begin
          cnt <= lag;
          st  <= 3'h2;
        end
        3'h2: if (cnt == 8'h00) begin
          bc_fetch      <= 1'b1;
          bc_fetch_addr <= bc_addr;
          st            <= 3'h3;
        end else begin
          cnt <= cnt - 8'h01;
        end
        3'h3: begin
          vec_rd <= 1'b1;
          st     <= 3'h4;
        end
        3'h4: begin
          // neither or both answers read as unknown
          got_hit  <= (bc_hit ^ bc_miss) ? bc_hit : 1'bx;
          got_data <= bc_data;
          st       <= 3'h5;
        end
        default: if (vec_valid) begin
          got      <= 1'b1;
          got_src  <= vec_src;
          got_addr <= vec_addr;
          got_none <= vec_none;
          st       <= 3'h0;
        end
      endcase
    end
  end
endmodule // dvic_cpu_model
